// >>> vout_uv_consts.vh
// command codes, field positions, reset values and timing for the output
// voltage supervision block; included by both design files
`ifndef VOUT_UV_CONSTS_VH
`define VOUT_UV_CONSTS_VH

`define CMD_VOUT_HIGH_WARN   8'h42
`define CMD_VOUT_LOW_WARN    8'h43
`define CMD_VOUT_LOW_FAULT   8'h44
`define CMD_VOUT_LOW_ACTION  8'h45

`define RST_VOUT_HIGH_WARN   16'hFFFF
`define RST_VOUT_LOW_WARN    16'h0000
`define RST_VOUT_LOW_FAULT   16'h0000
`define RST_VOUT_LOW_ACTION  8'h00

`define VOUT_EXPONENT        (-5)

`define ACT_DELAY_MSB        2
`define ACT_DELAY_LSB        0
`define ACT_RETRY_MSB        5
`define ACT_RETRY_LSB        3
`define ACT_MODE_MSB         7
`define ACT_MODE_LSB         6

`define MODE_IGNORE          2'h0
`define MODE_DISABLE_RETRY   2'h2
`define RETRY_NONE           3'h0
`define RETRY_FOREVER        3'h7

`define DELAY_UNIT_MS        200
`define CLK_PERIOD_NS        10
`define DELAY_UNIT_CYCLES    ((`DELAY_UNIT_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// >>> unit_delay_timer.v
// interval timer counting a 3-bit number of fixed delay units
// assumes one clock; start is a one-cycle pulse from the owner
`timescale 1ns/1ps
`include "vout_uv_consts.vh"

module unit_delay_timer #(
	parameter UNIT_CYCLES = `DELAY_UNIT_CYCLES,
	parameter PRE_W       = $clog2(UNIT_CYCLES + 1)
) (
	input  wire       clk,
	input  wire       rst_n,
	input  wire       start,
	input  wire [2:0] units,
	output wire       done
);

	reg [PRE_W-1:0] pre;
	reg [2:0]       left;
	reg             armed;
	wire            tick;

	// prescaler makes a one-cycle enable per delay unit
	assign tick = (pre == UNIT_CYCLES[PRE_W-1:0] - {{(PRE_W-1){1'b0}}, 1'b1});
	assign done = armed && (left == 3'h0);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre   <= {PRE_W{1'b0}};
			left  <= 3'h0;
			armed <= 1'b0;
		end else if (start) begin
			pre   <= {PRE_W{1'b0}};
			left  <= units;
			armed <= 1'b1;
		end else if (armed && left != 3'h0) begin
			if (tick) begin
				pre  <= {PRE_W{1'b0}};
				left <= left - 3'h1;
			end else begin
				pre <= pre + {{(PRE_W-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule

// >>> vout_low_fault_supervisor.v
// output voltage thresholds and the under-voltage fault response engine
// assumes command-code access from a bus front end, and a measured output
// voltage already in the same unsigned exponent -5 format as the thresholds
//
// Function
// [R01] Over-voltage warning threshold is a 16-bit read/write word at code 0x42.
// [R02] Under-voltage warning threshold is a 16-bit read/write word at code 0x43.
// [R03] Under-voltage fault threshold is a 16-bit read/write word at code 0x44.
// [R04] Bits 2:0 of the byte at code 0x45 give the restart delay in 200 ms units.
// [R05] Response 00 leaves the output running through an under-voltage fault.
// [R06] Response 10 turns the output off on the fault and follows the retry count.
// [R07] Retry count 000 keeps the output off until the fault is cleared.
// [R08] Retry counts 1 to 6 allow that many restarts, then stay off until cleared.
// [R09] Restart attempts start one delay interval apart, start to start.
// [R10] Retry count 111 retries forever until commanded off or another fault.
// [R11] Measured voltage below the fault threshold flags the fault and applies the response; the code does both only while outputEnable is high.
`timescale 1ns/1ps
`include "vout_uv_consts.vh"

module vout_low_fault_supervisor #(
	parameter UNIT_CYCLES = `DELAY_UNIT_CYCLES
) (
	input  wire        clk,
	input  wire        rst_n,
	input  wire [7:0]  cmdCode,
	input  wire        wrEn,
	input  wire [15:0] wrData,
	input  wire        rdEn,
	output reg  [15:0] rdData,
	output reg         rdValid,
	input  wire [15:0] voutMeas,
	input  wire        convertOn,
	input  wire        otherFault,
	input  wire        faultClear,
	output wire        outputEnable,
	output reg         highWarn,
	output reg         lowWarn,
	output reg         lowFault,
	output wire        retrying,
	output wire        latchedOff
);

	localparam [4:0] ST_IDLE  = 5'h01;
	localparam [4:0] ST_RUN   = 5'h02;
	localparam [4:0] ST_WAIT  = 5'h04;
	localparam [4:0] ST_TRY   = 5'h08;
	localparam [4:0] ST_LATCH = 5'h10;

	reg  [15:0] vout_high_warn_threshold;
	reg  [15:0] vout_low_warn_threshold;
	reg  [15:0] vout_low_fault_threshold;
	reg  [7:0]  vout_low_fault_action;

	reg  [4:0]  state;
	reg  [4:0]  next_state;
	reg  [2:0]  triesDone;
	reg  [2:0]  next_triesDone;
	reg         timerStart;

	wire [1:0]  actMode;
	wire [2:0]  actRetries;
	wire [2:0]  actDelay;
	wire        belowFault;
	wire        disableOnFault;
	wire        timerDone;
	wire        runAllowed;
	wire        triesLeft;

	// field split of the action byte
	assign actDelay   = vout_low_fault_action[`ACT_DELAY_MSB:`ACT_DELAY_LSB]; // [R04]
	assign actRetries = vout_low_fault_action[`ACT_RETRY_MSB:`ACT_RETRY_LSB];
	assign actMode    = vout_low_fault_action[`ACT_MODE_MSB:`ACT_MODE_LSB];

	// only 10 shuts down; the undefined codes behave as ignore
	assign disableOnFault = (actMode == `MODE_DISABLE_RETRY); // [R05] [R06]
	assign belowFault     = (voutMeas < vout_low_fault_threshold); // [R11]
	assign runAllowed     = convertOn && !otherFault; // [R10]

	// 111 never runs out of attempts
	assign triesLeft = (actRetries == `RETRY_FOREVER) || (triesDone < actRetries); // [R08] [R10]

	assign outputEnable = (state == ST_RUN) || (state == ST_TRY);
	assign retrying     = (state == ST_WAIT) || (state == ST_TRY);
	assign latchedOff   = (state == ST_LATCH);

	// register writes by command code
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			vout_high_warn_threshold <= `RST_VOUT_HIGH_WARN;
			vout_low_warn_threshold  <= `RST_VOUT_LOW_WARN;
			vout_low_fault_threshold <= `RST_VOUT_LOW_FAULT;
			vout_low_fault_action    <= `RST_VOUT_LOW_ACTION;
		end else if (wrEn) begin
			case (cmdCode)
				`CMD_VOUT_HIGH_WARN: begin
					vout_high_warn_threshold <= wrData; // [R01]
				end
				`CMD_VOUT_LOW_WARN: begin
					vout_low_warn_threshold <= wrData; // [R02]
				end
				`CMD_VOUT_LOW_FAULT: begin
					vout_low_fault_threshold <= wrData; // [R03]
				end
				`CMD_VOUT_LOW_ACTION: begin
					vout_low_fault_action <= wrData[7:0]; // [R04]
				end
				default: begin
				end
			endcase
		end
	end

	// read data one cycle after rdEn; unknown codes read zero
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData  <= 16'h0000;
			rdValid <= 1'b0;
		end else begin
			rdValid <= rdEn;
			if (rdEn) begin
				case (cmdCode)
					`CMD_VOUT_HIGH_WARN: begin
						rdData <= vout_high_warn_threshold; // [R01]
					end
					`CMD_VOUT_LOW_WARN: begin
						rdData <= vout_low_warn_threshold; // [R02]
					end
					`CMD_VOUT_LOW_FAULT: begin
						rdData <= vout_low_fault_threshold; // [R03]
					end
					`CMD_VOUT_LOW_ACTION: begin
						rdData <= {8'h00, vout_low_fault_action};
					end
					default: begin
						rdData <= 16'h0000;
					end
				endcase
			end
		end
	end

	// warnings follow the measurement; the fault flag is sticky
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			highWarn <= 1'b0;
			lowWarn  <= 1'b0;
			lowFault <= 1'b0;
		end else begin
			highWarn <= (voutMeas > vout_high_warn_threshold); // [R01]
			lowWarn  <= (voutMeas < vout_low_warn_threshold); // [R02]
			// a new fault in the clear cycle wins over the clear
			if (belowFault && outputEnable) begin
				lowFault <= 1'b1; // [R11]
			end else if (faultClear) begin
				lowFault <= 1'b0;
			end
		end
	end

	// response engine
	always @* begin
		next_state     = state;
		next_triesDone = triesDone;
		timerStart     = 1'b0;
		case (state)
			ST_IDLE: begin
				if (runAllowed) begin
					next_state     = ST_RUN;
					next_triesDone = 3'h0;
				end
			end
			ST_RUN: begin
				if (!runAllowed) begin
					next_state = ST_IDLE;
				end else if (belowFault && disableOnFault) begin
					// output drops; the first attempt waits one interval
					next_triesDone = 3'h0;
					timerStart     = 1'b1;
					if (actRetries == `RETRY_NONE) begin
						next_state = ST_LATCH; // [R07]
					end else begin
						next_state = ST_WAIT; // [R06]
					end
				end
			end
			ST_WAIT: begin
				if (!runAllowed) begin
					next_state = ST_IDLE; // [R10]
				end else if (timerDone) begin
					if (triesLeft) begin
						// interval restarts at the start of each attempt
						next_state     = ST_TRY; // [R09]
						next_triesDone = triesDone + 3'h1;
						timerStart     = 1'b1;
					end else begin
						next_state = ST_LATCH; // [R08]
					end
				end
			end
			ST_TRY: begin
				if (!runAllowed) begin
					next_state = ST_IDLE; // [R10]
				end else if (belowFault) begin
					// timer keeps running so attempts stay start to start
					next_state = ST_WAIT; // [R09]
				end else if (timerDone) begin
					next_state     = ST_RUN;
					next_triesDone = 3'h0;
				end
			end
			ST_LATCH: begin
				if (!runAllowed) begin
					next_state = ST_IDLE;
				end else if (faultClear) begin
					next_state     = ST_RUN; // [R07] [R08]
					next_triesDone = 3'h0;
				end
			end
			default: begin
				next_state     = ST_IDLE;
				next_triesDone = 3'h0;
			end
		endcase
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state     <= ST_IDLE;
			triesDone <= 3'h0;
		end else begin
			state     <= next_state;
			triesDone <= next_triesDone;
		end
	end

	// delay unit is long; the parameter lets simulation shrink it
	unit_delay_timer #(
		.UNIT_CYCLES (UNIT_CYCLES)
	) u_delay (
		.clk   (clk),
		.rst_n (rst_n),
		.start (timerStart),
		.units (actDelay),
		.done  (timerDone)
	);

endmodule

// >>> vout_low_fault_supervisor_monitor.sv
// port assertions for the under-voltage supervisor
// assumes one clock and the async active-low reset
`timescale 1ns/1ps
module vout_low_fault_supervisor_monitor (
	input logic        clk,
	input logic        rst_n,
	input logic [7:0]  cmdCode,
	input logic        rdEn,
	input logic [15:0] rdData,
	input logic        rdValid,
	input logic        convertOn,
	input logic        otherFault,
	input logic        faultClear,
	input logic        outputEnable,
	input logic        lowFault,
	input logic        latchedOff
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_read;
		rdEn ##1 rdValid;
	endsequence
	a_read_valid: assert property (rdEn |-> s_read)
		else $error("no rdValid after rdEn");
	a_unmapped_zero: assert property (rdEn && !(cmdCode inside {[8'h42:8'h45]})
		|=> rdData == 16'h0000) else $error("unmapped read not zero");
	a_rdata_hold: assert property (!rdEn |=> $stable(rdData))
		else $error("rdData moved without rdEn");
	a_fault_cause: assert property ($rose(lowFault) |-> $past(outputEnable))
		else $error("fault flagged with output off");
	a_fault_sticky: assert property (lowFault && !faultClear |=> lowFault)
		else $error("fault flag dropped");
	a_shutdown_pair: assert property ($fell(outputEnable) && $past(convertOn)
		&& !$past(otherFault) |-> lowFault) else $error("shutdown without fault");
	a_latch_off: assert property (latchedOff |-> !outputEnable)
		else $error("output on while latched");
	a_latch_hold: assert property (latchedOff && convertOn && !otherFault && !faultClear
		|=> latchedOff) else $error("latched state left without clear");
	a_off_cmd: assert property (!convertOn || otherFault |=> !outputEnable)
		else $error("output on while commanded off");
endmodule

// >>> pmbus_host_model.sv
// host side of the command-code register port
// drives at falling edges; released data lines show inverted data
`timescale 1ns/1ps
module pmbus_host_model (
	input  logic        clk,
	output logic [7:0]  cmdCode,
	output logic        wrEn,
	output logic [15:0] wrData,
	output logic        rdEn,
	input  logic [15:0] rdData,
	input  logic        rdValid
);
	initial begin
		cmdCode = 8'h00;
		wrEn = 1'b0;
		wrData = 16'h0000;
		rdEn = 1'b0;
	end
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(negedge clk);
		cmdCode = c;
		wrData = d;
		wrEn = 1'b1;
		@(negedge clk);
		wrEn = 1'b0;
		wrData = ~d;
	endtask
	// answer is registered at the taking edge, so it is settled half a cycle later here
	task automatic rd(input logic [7:0] c, output logic [15:0] d);
		@(negedge clk);
		cmdCode = c;
		rdEn = 1'b1;
		@(negedge clk);
		rdEn = 1'b0;
		d = (rdValid === 1'b1) ? rdData : 16'hDEAD;
	endtask
endmodule

// >>> vout_low_fault_supervisor_tb_top.sv
// register and fault-response tests for the supervisor
// assumes the host model and a short delay unit of 10 cycles
`timescale 1ns/1ps
`include "vout_uv_consts.vh"
module vout_low_fault_supervisor_tb_top;
	logic        clk = 1'b0;
	logic        rst_n, rdEn, wrEn, rdValid, convertOn, otherFault, faultClear;
	logic        outputEnable, highWarn, lowWarn, lowFault, retrying, latchedOff, prevOe;
	logic [7:0]  cmdCode;
	logic [15:0] wrData, rdData, voutMeas, got;
	int          errTotal = 0, nChecks = 0, rises = 0, cy = 0, tRise = 0, r0, t1;
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cy <= cy + 1;
		prevOe <= outputEnable;
		if (outputEnable && !prevOe) begin
			rises <= rises + 1;
			tRise <= cy;
		end
	end
	pmbus_host_model i_host (.clk(clk), .cmdCode(cmdCode), .wrEn(wrEn), .wrData(wrData),
		.rdEn(rdEn), .rdData(rdData), .rdValid(rdValid));
	vout_low_fault_supervisor #(.UNIT_CYCLES(10)) i_dut (.clk(clk), .rst_n(rst_n),
		.cmdCode(cmdCode), .wrEn(wrEn), .wrData(wrData), .rdEn(rdEn), .rdData(rdData),
		.rdValid(rdValid), .voutMeas(voutMeas), .convertOn(convertOn),
		.otherFault(otherFault), .faultClear(faultClear), .outputEnable(outputEnable),
		.highWarn(highWarn), .lowWarn(lowWarn), .lowFault(lowFault),
		.retrying(retrying), .latchedOff(latchedOff));
	task chk(input logic [15:0] g, input logic [15:0] e);
		nChecks++;
		if (g !== e) begin
			errTotal++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task rdchk(input logic [7:0] c, input logic [15:0] e);
		i_host.rd(c, got);
		chk(got, e);
	endtask
	task cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task wait_rises(input int n);
		repeat (500) if (rises < n) @(negedge clk);
		if (rises < n) begin
			errTotal++;
			$display("Error at %0t: restart attempt missing", $time);
		end
	endtask
	task pulse_clear;
		@(negedge clk) faultClear = 1'b1;
		@(negedge clk) faultClear = 1'b0;
	endtask
	task giveVerdict;
		if (errTotal == 0 && nChecks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// run needs under 1000 cycles; ten times that means a hang
	initial begin
		#100000;
		errTotal++;
		giveVerdict;
	end
	initial begin
		rst_n = 1'b0;
		voutMeas = 16'h0200;
		convertOn = 1'b1;
		otherFault = 1'b0;
		faultClear = 1'b0;
		repeat (4) @(posedge clk);
		@(negedge clk) rst_n = 1'b1;
		rdchk(`CMD_VOUT_HIGH_WARN, 16'hFFFF);
		rdchk(`CMD_VOUT_LOW_WARN, 16'h0000);
		rdchk(`CMD_VOUT_LOW_FAULT, 16'h0000);
		rdchk(`CMD_VOUT_LOW_ACTION, 16'h0000);
		i_host.wr(8'h46, 16'h1234);
		rdchk(8'h46, 16'h0000);
		i_host.wr(`CMD_VOUT_HIGH_WARN, 16'h0300);
		rdchk(`CMD_VOUT_HIGH_WARN, 16'h0300);
		i_host.wr(`CMD_VOUT_LOW_WARN, 16'h0180);
		rdchk(`CMD_VOUT_LOW_WARN, 16'h0180);
		i_host.wr(`CMD_VOUT_LOW_FAULT, 16'h0100);
		rdchk(`CMD_VOUT_LOW_FAULT, 16'h0100);
		i_host.wr(`CMD_VOUT_LOW_ACTION, 16'hAB01);
		rdchk(`CMD_VOUT_LOW_ACTION, 16'h0001);
		// ignore mode: flag only, power stays up
		voutMeas = 16'h0080;
		cyc(3);
		chk(16'(lowWarn), 16'h0001);
		chk(16'(lowFault), 16'h0001);
		chk(16'(outputEnable), 16'h0001);
		// undefined code 11 must not shut down either
		i_host.wr(`CMD_VOUT_LOW_ACTION, 16'h00C1);
		cyc(3);
		chk(16'(outputEnable), 16'h0001);
		voutMeas = 16'h0400;
		cyc(3);
		chk(16'(highWarn), 16'h0001);
		voutMeas = 16'h0200;
		pulse_clear;
		chk(16'(lowFault), 16'h0000);
		i_host.wr(`CMD_VOUT_LOW_ACTION, 16'h0081);
		voutMeas = 16'h0080;
		cyc(3);
		chk(16'(outputEnable), 16'h0000);
		cyc(40);
		chk(16'(latchedOff), 16'h0001);
		voutMeas = 16'h0200;
		pulse_clear;
		cyc(3);
		chk(16'(outputEnable), 16'h0001);
		i_host.wr(`CMD_VOUT_LOW_ACTION, 16'h0091);
		r0 = rises;
		voutMeas = 16'h0080;
		cyc(100);
		chk(16'(rises - r0), 16'h0002);
		chk(16'(latchedOff), 16'h0001);
		voutMeas = 16'h0200;
		pulse_clear;
		i_host.wr(`CMD_VOUT_LOW_ACTION, 16'h00BB);
		r0 = rises;
		voutMeas = 16'h0080;
		wait_rises(r0 + 2);
		t1 = tRise;
		wait_rises(r0 + 3);
		// one cycle of slack for the timer start edge
		chk(16'(tRise - t1 >= 30 && tRise - t1 <= 31), 16'h0001);
		cyc(300);
		chk(16'(rises - r0 > 7), 16'h0001);
		chk(16'(latchedOff), 16'h0000);
		convertOn = 1'b0;
		cyc(2);
		chk(16'({outputEnable, retrying}), 16'h0000);
		voutMeas = 16'h0200;
		convertOn = 1'b1;
		cyc(3);
		chk(16'(outputEnable), 16'h0001);
		otherFault = 1'b1;
		cyc(2);
		chk(16'(outputEnable), 16'h0000);
		// mid-run reset puts written registers back
		otherFault = 1'b0;
		rst_n = 1'b0;
		cyc(2);
		rst_n = 1'b1;
		rdchk(`CMD_VOUT_HIGH_WARN, `RST_VOUT_HIGH_WARN);
		rdchk(`CMD_VOUT_LOW_FAULT, `RST_VOUT_LOW_FAULT);
		rdchk(`CMD_VOUT_LOW_ACTION, {8'h00, `RST_VOUT_LOW_ACTION});
		chk(16'({outputEnable, lowFault}), 16'h0002);
		giveVerdict;
	end
endmodule
bind vout_low_fault_supervisor vout_low_fault_supervisor_monitor i_mon (.clk(clk),
	.rst_n(rst_n), .cmdCode(cmdCode), .rdEn(rdEn), .rdData(rdData), .rdValid(rdValid),
	.convertOn(convertOn), .otherFault(otherFault), .faultClear(faultClear),
	.outputEnable(outputEnable), .lowFault(lowFault), .latchedOff(latchedOff));
